// File: lss_defines.vh
`ifndef LSS_DEFINES_VH
`define LSS_DEFINES_VH
// reference clock
`define LSS_CLK_HZ 20000000
// shutdown interval, detection delay, soft-start ramp (microseconds)
`define LSS_T_OFF_US 16000
`define LSS_T_DET_US 1500
`define LSS_T_SS_US 16000
`define LSS_OFF_CYC ((`LSS_T_OFF_US * (`LSS_CLK_HZ / 1000000)))
`define LSS_DET_CYC ((`LSS_T_DET_US * (`LSS_CLK_HZ / 1000000)))
`define LSS_SS_CYC ((`LSS_T_SS_US * (`LSS_CLK_HZ / 1000000)))
// channel count and classification codes
`define LSS_NCH 6
`define LSS_CLS_SHORT 2'h0
`define LSS_CLS_UNUSED 2'h1
`define LSS_CLS_USED 2'h2
// counter width
`define LSS_CW 20
`endif

// File: lss_sync.v
`timescale 1ns/1ns
// =====================================================================
// two-flop synchroniser, vector wide
module lss_sync #(
   parameter W = 1
) (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // data
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
      end
      else
      begin
         s1_q <= d;
         s2_q <= s1_q;
      end
   end
   assign q = s2_q;
endmodule

// File: lss_sequencer.v
// Summary of operation
// - leave off only when enable high and supply above lockout
// - boost and sinks each enabled separately by enable-dimming high
// - power-up checks for shorts and open pins; switch only if clean
// - enable low longer than shutdown interval turns device fully off
// - detection starts on first dimming-high after disconnect gate reaches its target level
// - after led pin above low threshold, wait fixed delay, then decide
// - classify each channel as short fault, unused, or in use
// - unused channels disabled and removed from boost feedback
// - pin shorts assert fault output and retry until short removed
// - fault output released at end of detection phase
// - no soft-start unless output rises above undervoltage threshold
// - output undervoltage fault shuts down at once and latches off
// - latch cleared by lockout or long enable-low shutdown
// - latch also cleared by long dimming-low with enable high
// - soft-start ramps reference at fixed slope, dimming independent
// - soft-start ends on regulation, 93 percent threshold, or timeout
// - startup order: checks, disconnect, detection, soft-start
// - pull gate down gradually, then enable current reference, wait
// - first dimming-high after reference enable triggers detection
// - short pulses run open loop at overvoltage level, else closed
// - while dimming low, float compensation, await next rising edge
`timescale 1ns/1ns
`include "lss_defines.vh"
module lss_sequencer #(
   parameter NCH = `LSS_NCH,
   parameter OFF_CYC = `LSS_OFF_CYC,
   parameter DET_CYC = `LSS_DET_CYC,
   parameter SS_CYC = `LSS_SS_CYC,
   parameter RW = 8
) (
   // clock and reset
   input wire I_CLK,
   input wire I_NRST,
   // host pins
   input wire I_EN_DIM,
   input wire I_DIM_LOW_ONLY,
   // analog comparators
   input wire I_INPUT_SUPPLY_LOCKOUT_OK,
   input wire I_VOUT_SHORT,
   input wire I_FREQUENCY_SET_PIN_FAULT,
   input wire I_CURRENT_SET_PIN_FAULT,
   input wire I_GATE_AT_TARGET,
   input wire I_OUTPUT_UNDERVOLTAGE_FAULT,
   input wire I_VOUT_NEAR_OVP,
   input wire I_SHORT_PULSE,
   input wire [NCH-1:0] I_LED_ABOVE_LOW,
   input wire [NCH-1:0] I_LED_ABOVE_MID,
   input wire [NCH-1:0] I_LED_ABOVE_HIGH,
   input wire [NCH-1:0] I_LED_IN_REG,
   // control outputs
   output reg O_POWERED,
   output reg O_GATE_PULL,
   output reg O_CURRENT_SET_PIN_EN,
   output reg O_BOOST_EN,
   output reg [NCH-1:0] O_SINK_EN,
   output reg [NCH-1:0] O_FB_EN,
   output reg O_SS_ACTIVE,
   output reg [RW-1:0] O_SS_REF,
   output reg O_OPEN_LOOP,
   output reg O_COMP_FLOAT,
   output reg O_LATCHED,
   // open-drain fault, enable high pulls low
   output wire O_FAULT_OUT,
   output reg O_FAULT_OE
);
   // ==================================================================
   // reset release and input synchronisation
   reg rs1_q;
   reg rst_n;
   always @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         rs1_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rs1_q <= 1'b1;
         rst_n <= rs1_q;
      end
   end
   localparam SW = 10 + 4 * NCH;
   wire [SW-1:0] s;
   lss_sync #(.W(SW)) u_sync (
      .clk(I_CLK),
      .rst_n(rst_n),
      .d({I_EN_DIM, I_DIM_LOW_ONLY, I_INPUT_SUPPLY_LOCKOUT_OK,
          I_VOUT_SHORT, I_FREQUENCY_SET_PIN_FAULT,
          I_CURRENT_SET_PIN_FAULT, I_GATE_AT_TARGET,
          I_OUTPUT_UNDERVOLTAGE_FAULT, I_VOUT_NEAR_OVP, I_SHORT_PULSE,
          I_LED_ABOVE_LOW, I_LED_ABOVE_MID, I_LED_ABOVE_HIGH,
          I_LED_IN_REG}),
      .q(s)
   );
   wire en = s[SW-1];
   wire dim_low = s[SW-2];
   wire uvlo_ok = s[SW-3];
   wire vout_short = s[SW-4];
   wire frequency_set_pin_flt = s[SW-5];
   wire current_set_pin_flt = s[SW-6];
   wire gate_ok = s[SW-7];
   wire output_undervoltage_fault = s[SW-8];
   wire near_ovp = s[SW-9];
   wire short_pulse = s[SW-10];
   wire [NCH-1:0] above_low = s[4*NCH-1:3*NCH];
   wire [NCH-1:0] above_mid = s[3*NCH-1:2*NCH];
   wire [NCH-1:0] above_high = s[2*NCH-1:NCH];
   wire [NCH-1:0] in_reg = s[NCH-1:0];
   // dimming high means enable pin high and dimming not forced low
   wire dim_hi = en & ~dim_low;
   // ==================================================================
   // state machine
   localparam ST_OFF = 7'h01;
   localparam ST_CHECK = 7'h02;
   localparam ST_GATE = 7'h04;
   localparam ST_WAIT = 7'h08;
   localparam ST_DET = 7'h10;
   localparam ST_SS = 7'h20;
   localparam ST_RUN = 7'h40;
   reg [6:0] st_q;
   reg [6:0] st_d;
   reg en_q;
   reg [`LSS_CW-1:0] off_cnt_q;
   reg [`LSS_CW-1:0] dl_cnt_q;
   reg [`LSS_CW-1:0] t_q;
   reg latch_q;
   reg [NCH-1:0] unused_q;
   wire en_rise = en & ~en_q;
   wire off_exp = (off_cnt_q >= OFF_CYC[`LSS_CW-1:0]);
   wire dl_exp = (dl_cnt_q >= OFF_CYC[`LSS_CW-1:0]);
   wire pin_flt = frequency_set_pin_flt | current_set_pin_flt | vout_short;
   // classify one channel from its low and high comparators; mid is ignored
   function [1:0] cls;
      input lo;
      input mid;
      input hi;
      begin
         if (!lo)
            cls = `LSS_CLS_SHORT;
         else if (hi)
            cls = `LSS_CLS_USED;
         else
            cls = `LSS_CLS_UNUSED;
      end
   endfunction
   reg [NCH-1:0] sh_now;
   reg [NCH-1:0] un_now;
   integer k;
   always @*
   begin
      sh_now = {NCH{1'b0}};
      un_now = {NCH{1'b0}};
      for (k = 0; k < NCH; k = k + 1)
      begin
         sh_now[k] = (cls(above_low[k], above_mid[k], above_high[k])
                      == `LSS_CLS_SHORT);
         un_now[k] = (cls(above_low[k], above_mid[k], above_high[k])
                      == `LSS_CLS_UNUSED);
      end
   end
   wire any_short = |sh_now;
   wire t_det = (t_q >= DET_CYC[`LSS_CW-1:0] - 1'b1);
   wire t_ss = (t_q >= SS_CYC[`LSS_CW-1:0] - 1'b1);
   wire all_reg = &(in_reg | unused_q);
   // output rose above undervoltage threshold means no uvp flag
   wire near_ovp_ok = ~output_undervoltage_fault;
   always @*
   begin
      st_d = st_q;
      case (st_q)
         ST_OFF:
            if (en && uvlo_ok && !latch_q)
               st_d = ST_CHECK;
         ST_CHECK:
            if (!pin_flt)
               st_d = ST_GATE;
         ST_GATE:
            if (gate_ok)
               st_d = ST_WAIT;
         ST_WAIT:
            if (pin_flt)
               st_d = ST_CHECK;
            else if (dim_hi)
               st_d = ST_DET;
         ST_DET:
            if (pin_flt)
               st_d = ST_CHECK;
            else if (t_det && !any_short && near_ovp_ok)
               st_d = ST_SS;
         ST_SS:
            if (near_ovp || all_reg || t_ss)
               st_d = ST_RUN;
         ST_RUN:
            st_d = ST_RUN;
         default:
            st_d = ST_OFF;
      endcase
      if (!uvlo_ok || off_exp || output_undervoltage_fault || latch_q)
         st_d = ST_OFF;
   end
   always @(posedge I_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= ST_OFF;
         en_q <= 1'b0;
         off_cnt_q <= {`LSS_CW{1'b0}};
         dl_cnt_q <= {`LSS_CW{1'b0}};
         t_q <= {`LSS_CW{1'b0}};
         latch_q <= 1'b0;
         unused_q <= {NCH{1'b0}};
      end
      else
      begin
         st_q <= st_d;
         en_q <= en;
         // long-low counter restarts on any rising edge
         if (en_rise || en)
            off_cnt_q <= {`LSS_CW{1'b0}};
         else if (!off_exp)
            off_cnt_q <= off_cnt_q + 1'b1;
         if (!en || !dim_low)
            dl_cnt_q <= {`LSS_CW{1'b0}};
         else if (!dl_exp)
            dl_cnt_q <= dl_cnt_q + 1'b1;
         // set wins over clear
         if (output_undervoltage_fault && st_q != ST_OFF && st_q != ST_CHECK)
            latch_q <= 1'b1;
         else if (!uvlo_ok || off_exp || dl_exp)
            latch_q <= 1'b0;
         // detection timer starts once led pins pass the low threshold
         if (st_q != st_d)
            t_q <= {`LSS_CW{1'b0}};
         else if ((st_q == ST_DET && (|above_low)) || st_q == ST_SS)
            t_q <= t_q + 1'b1;
         if (st_q == ST_DET && st_d == ST_SS)
            unused_q <= un_now;
         else if (st_q == ST_OFF)
            unused_q <= {NCH{1'b0}};
      end
   end
   // ==================================================================
   // outputs
   // one ramp step every RSTEP cycles spreads full scale over the timer
   localparam RSTEP = ((SS_CYC >> RW) > 0) ? (SS_CYC >> RW) : 1;
   reg [`LSS_CW-1:0] pre_q;
   wire step = (pre_q >= RSTEP[`LSS_CW-1:0] - 1'b1);
   // mask already valid in the first soft-start cycle
   wire [NCH-1:0] use_mask = (st_q == ST_DET) ? ~un_now : ~unused_q;
   always @(posedge I_CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         O_POWERED <= 1'b0;
         O_GATE_PULL <= 1'b0;
         O_CURRENT_SET_PIN_EN <= 1'b0;
         O_BOOST_EN <= 1'b0;
         O_SINK_EN <= {NCH{1'b0}};
         O_FB_EN <= {NCH{1'b0}};
         O_SS_ACTIVE <= 1'b0;
         O_SS_REF <= {RW{1'b0}};
         pre_q <= {`LSS_CW{1'b0}};
         O_OPEN_LOOP <= 1'b0;
         O_COMP_FLOAT <= 1'b0;
         O_LATCHED <= 1'b0;
         O_FAULT_OE <= 1'b0;
      end
      else
      begin
         O_POWERED <= (st_d != ST_OFF);
         O_GATE_PULL <= (st_d != ST_OFF) && (st_d != ST_CHECK);
         O_CURRENT_SET_PIN_EN <= (st_d == ST_WAIT) || (st_d == ST_DET) ||
                      (st_d == ST_SS) || (st_d == ST_RUN);
         O_BOOST_EN <= dim_hi &&
                       (st_d == ST_SS || st_d == ST_RUN);
         O_SINK_EN <= (dim_hi && (st_d == ST_SS || st_d == ST_RUN)) ?
                      use_mask : {NCH{1'b0}};
         O_FB_EN <= (st_d == ST_SS || st_d == ST_RUN) ?
                    use_mask : {NCH{1'b0}};
         O_SS_ACTIVE <= (st_d == ST_SS);
         // slope from prescaled timer only, dimming does not gate it
         if (st_q != ST_SS || step)
            pre_q <= {`LSS_CW{1'b0}};
         else
            pre_q <= pre_q + 1'b1;
         if (st_q == ST_SS && step && O_SS_REF != {RW{1'b1}})
            O_SS_REF <= O_SS_REF + 1'b1;
         else if (st_q == ST_RUN)
            O_SS_REF <= {RW{1'b1}};
         else if (st_q != ST_SS)
            O_SS_REF <= {RW{1'b0}};
         O_OPEN_LOOP <= (st_d == ST_RUN) && short_pulse;
         O_COMP_FLOAT <= (st_d == ST_SS || st_d == ST_RUN) &&
                         !dim_hi;
         O_LATCHED <= latch_q;
         if (st_q == ST_DET && st_d == ST_SS)
            O_FAULT_OE <= 1'b0;
         else if (pin_flt && st_q != ST_OFF)
            O_FAULT_OE <= 1'b1;
         else if ((st_q == ST_DET) && t_det && any_short)
            O_FAULT_OE <= 1'b1;
         else if (st_q == ST_OFF)
            O_FAULT_OE <= latch_q;
      end
   end
   assign O_FAULT_OUT = 1'b0;
endmodule

// File: lss_monitor.sv
`timescale 1ns/1ns
// ==========================================
// port checker for the start-up sequencer
module lss_monitor #(
   parameter NCH = 6,
   parameter OFF_CYC = 64,
   parameter SS_CYC = 64,
   parameter RW = 8
) (
   // clock, reset, host and comparator inputs
   input wire I_CLK,
   input wire I_NRST,
   input wire I_EN_DIM,
   input wire I_FREQUENCY_SET_PIN_FAULT,
   // sequencer outputs
   input wire O_POWERED,
   input wire O_CURRENT_SET_PIN_EN,
   input wire O_BOOST_EN,
   input wire [NCH-1:0] O_SINK_EN,
   input wire O_SS_ACTIVE,
   input wire [RW-1:0] O_SS_REF,
   input wire O_LATCHED,
   input wire O_FAULT_OE
);
   reg [19:0] low_q;
   reg [19:0] ss_q;
   always @(posedge I_CLK or negedge I_NRST)
      if (!I_NRST)
      begin
         low_q <= 20'h0;
         ss_q <= 20'h0;
      end
      else
      begin
         low_q <= I_EN_DIM ? 20'h0 : low_q + 20'h1;
         ss_q <= O_SS_ACTIVE ? ss_q + 20'h1 : 20'h0;
      end
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);
   stay_off_a: assert property (
      !I_EN_DIM [*6] ##0 !O_POWERED |=> !O_POWERED)
      else $error("woke with enable low");
   long_low_a: assert property (
      low_q > OFF_CYC + 8 |-> !O_POWERED)
      else $error("no shutdown after long low");
   sink_gate_a: assert property (!I_EN_DIM [*5] |-> O_SINK_EN == 0)
      else $error("sinks on with dimming low");
   ss_order_a: assert property ($rose(O_SS_ACTIVE) |->
      O_POWERED && O_CURRENT_SET_PIN_EN && !O_LATCHED)
      else $error("soft-start out of order");
   fault_rel_a: assert property (O_SS_ACTIVE |-> !O_FAULT_OE)
      else $error("fault held in soft-start");
   ss_timer_a: assert property (ss_q <= SS_CYC + 4)
      else $error("soft-start overran timer");
   ramp_up_a: assert property (
      O_SS_ACTIVE && $past(O_SS_ACTIVE) |-> O_SS_REF >= $past(O_SS_REF))
      else $error("ramp went down");
   uvp_stop_a: assert property ($rose(O_LATCHED) |->
      ##[0:1] !O_BOOST_EN && !O_SS_ACTIVE)
      else $error("latched fault did not stop");
   pin_fault_a: assert property (
      I_FREQUENCY_SET_PIN_FAULT [*6] ##0 O_POWERED && !O_CURRENT_SET_PIN_EN
      |-> ##[0:2] O_FAULT_OE)
      else $error("pin fault not flagged");
   cover property ($rose(O_SS_ACTIVE));
   cover property ($fell(O_LATCHED));
   cover property ($rose(O_FAULT_OE));
endmodule

bind lss_sequencer lss_monitor #(.NCH(NCH), .OFF_CYC(OFF_CYC),
   .SS_CYC(SS_CYC), .RW(RW)) u_mon (.I_CLK(I_CLK), .I_NRST(I_NRST),
   .I_EN_DIM(I_EN_DIM), .I_FREQUENCY_SET_PIN_FAULT(I_FREQUENCY_SET_PIN_FAULT),
   .O_POWERED(O_POWERED), .O_CURRENT_SET_PIN_EN(O_CURRENT_SET_PIN_EN), .O_BOOST_EN(O_BOOST_EN),
   .O_SINK_EN(O_SINK_EN), .O_SS_ACTIVE(O_SS_ACTIVE), .O_SS_REF(O_SS_REF),
   .O_LATCHED(O_LATCHED), .O_FAULT_OE(O_FAULT_OE));

// File: lss_host.sv
`timescale 1ns/1ns
// ==========================================
// host: drives enable pin, reads pulled-up fault line
module lss_host (
   // clock and command
   input wire clk,
   input wire [1:0] mode,
   input wire fault_n,
   // pins
   output reg en_dim,
   output reg dim_low_only,
   output reg fault_seen
);
   reg [3:0] ph_q = 4'h0;
   initial en_dim = 1'b0;
   initial dim_low_only = 1'b0;
   initial fault_seen = 1'b0;
   // mode 0 off, 1 on, 2 pwm 9/16, 3 enable high dimming low
   always @(posedge clk)
   begin
      ph_q <= ph_q + 4'h1;
      en_dim <= mode != 2'h0 && (mode != 2'h2 || ph_q < 4'h9);
      dim_low_only <= mode == 2'h3;
      fault_seen <= mode != 2'h0 && (fault_seen || !fault_n);
   end
endmodule

// File: led_driver_startup_sequencer_tb_top.sv
`timescale 1ns/1ns
// ==========================================
// top-level bench
module led_driver_startup_sequencer_tb_top;
   localparam OFF = 64;
   localparam SS = 64;
   reg clk, nrst = 1'b0, lock_ok = 1'b0, frequency_set_pin_f = 1'b0, current_set_pin_f = 1'b0;
   reg gate_ok = 1'b0, output_undervoltage_fault = 1'b0, near_ovp = 1'b0, shp = 1'b0;
   reg [5:0] lo = 6'h0, mid = 6'h0, hi = 6'h0, inreg = 6'h0;
   reg [1:0] mode = 2'h0;
   reg [1:0] ss_d = 2'h0;
   reg [31:0] seed = 32'h8E55;
   logic [5:0] expq[$];
   int bad_count = 0, compares = 0;
   wire en_dim, dlo, fseen, pwr, gpull, ssa, latd, fout, foe, oloop, cflt;
   wire [5:0] fb;
   wire fault_n = foe ? fout : 1'b1;
   lss_host u_host (.clk(clk), .mode(mode), .fault_n(fault_n),
      .en_dim(en_dim), .dim_low_only(dlo), .fault_seen(fseen));
   lss_sequencer #(.OFF_CYC(OFF), .DET_CYC(32), .SS_CYC(SS)) u_dut (
      .I_CLK(clk), .I_NRST(nrst), .I_EN_DIM(en_dim), .I_DIM_LOW_ONLY(dlo),
      .I_INPUT_SUPPLY_LOCKOUT_OK(lock_ok), .I_VOUT_SHORT(1'b0),
      .I_FREQUENCY_SET_PIN_FAULT(frequency_set_pin_f), .I_CURRENT_SET_PIN_FAULT(current_set_pin_f),
      .I_GATE_AT_TARGET(gate_ok), .I_OUTPUT_UNDERVOLTAGE_FAULT(output_undervoltage_fault),
      .I_VOUT_NEAR_OVP(near_ovp), .I_SHORT_PULSE(shp),
      .I_LED_ABOVE_LOW(lo), .I_LED_ABOVE_MID(mid), .I_LED_ABOVE_HIGH(hi),
      .I_LED_IN_REG(inreg), .O_POWERED(pwr), .O_GATE_PULL(gpull),
      .O_CURRENT_SET_PIN_EN(), .O_BOOST_EN(), .O_SINK_EN(), .O_FB_EN(fb),
      .O_SS_ACTIVE(ssa), .O_SS_REF(), .O_OPEN_LOOP(oloop),
      .O_COMP_FLOAT(cflt),
      .O_LATCHED(latd), .O_FAULT_OUT(fout), .O_FAULT_OE(foe));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task report_and_stop;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // disconnect gate settles one cycle after pull-down
   always @(posedge clk) gate_ok <= gpull;
   // compare feedback mask two cycles after soft-start begins
   always @(posedge clk)
   begin
      ss_d <= {ss_d[0], ssa};
      if (ss_d == 2'h1)
      begin
         if (expq.size() == 0) chk(32'h1, 32'h0);
         else chk(fb, expq.pop_front());
      end
   end
   // k: 0 clean, 1 led short, 2 freq pin, 3 current pin fault
   task boot(input int k);
      logic [5:0] used;
      int i;
      seed = xs(seed);
      used = seed[5:0] | 6'h01;
      expq.push_back(used);
      inreg <= 6'h0;
      lo <= k == 1 ? 6'h3E : 6'h3F;
      mid <= k == 1 ? 6'h3E : 6'h3F;
      hi <= k == 1 ? used & 6'h3E : used;
      frequency_set_pin_f <= k == 2;
      current_set_pin_f <= k == 3;
      mode <= 2'h1;
      if (k != 0)
      begin
         cyc(300);
         chk({fseen, ssa}, 2'h2);
         lo <= 6'h3F;
         mid <= 6'h3F;
         hi <= used;
         frequency_set_pin_f <= 1'b0;
         current_set_pin_f <= 1'b0;
      end
      for (i = 0; i < 800 && ssa !== 1'b1; i++) @(posedge clk);
      chk(ssa, 1);
      chk(foe, 1'b0);
      near_ovp <= k != 1 && k != 2;
      inreg <= k == 1 ? used : 6'h0;
      cyc(k == 2 ? SS + 8 : 8);
      chk(ssa, 0);
      near_ovp <= 1'b0;
      mode <= 2'h2;
      shp <= seed[6];
      cyc(120);
      chk(pwr, 1);
      chk(oloop, seed[6]);
      mode <= 2'h3;
      cyc(8);
      chk(cflt, 1);
      mode <= 2'h1;
      cyc(8);
      chk(cflt, 0);
      if (k == 0 || k == 3)
      begin
         output_undervoltage_fault <= 1'b1;
         cyc(6);
         chk(latd, 1);
         output_undervoltage_fault <= 1'b0;
         mode <= k == 0 ? 2'h3 : 2'h1;
         lock_ok <= k == 0;
         cyc(OFF + 20);
         chk(latd, 0);
         lock_ok <= 1'b1;
      end
      mode <= 2'h0;
      cyc(OFF + 20);
      chk(pwr, 0);
   endtask
   initial
   begin
      cyc(12);
      nrst <= 1'b1;
      mode <= 2'h1;
      cyc(30);
      chk(pwr, 0);
      mode <= 2'h0;
      lock_ok <= 1'b1;
      cyc(OFF + 20);
      for (int k = 0; k < 4; k++) boot(k);
      chk(expq.size(), 0);
      report_and_stop;
   end
   initial
   begin
      cyc(20000);
      bad_count = bad_count + 1;
      report_and_stop;
   end
endmodule
